// ===== inc/mbc_pkg.sv
// Operation
// - In a read's address phase the fetch pin shows whether it is a cache miss.
// - In a read's second interval the fetch pin is high for instruction fetches.
// - Address latch strobe is high while the bus holds the transfer address.
// - Bus release strobe asserts only after the device stops driving the bus.
// - Burst indicator on a read asks memory for four consecutive words.
// - Burst only on cache misses: every instruction miss, data misses if option set.
// - Same-page hint on a write following a write in the same 256 byte page.
// - Read cycle output is high for the whole of any read transaction.
// - Store cycle output is high for the whole of any write transaction.
// - On write acknowledge advance to the next narrow part or end the write.
// - On read acknowledge let the core start using that read's data.
// - Read buffer capture input loads bus data into the on-chip read buffer.
// - Reference clock output mirrors the system clock driving all state.
// - Each transfer has an address phase then a data phase on the same lines.
// - Burst reads count the low address from zero by the port width.
package mbc_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int LOW_W = 4;
	localparam int PAGE_LSB = 8;
	localparam int BURST_WORDS = 4;
	localparam int CNT_W = 2;
	localparam logic [LOW_W-1:0] LOW_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
	localparam logic [CNT_W-1:0] CNT_LAST = 2'h3;

	// Memory port widths.
	typedef enum logic [1:0] {PW_32, PW_16, PW_8} mbc_port_t;

	typedef enum {ST_IDLE, ST_ADDR, ST_TURN, ST_DATA} mbc_state_t;

	// Request from the core side.
	typedef struct packed {
		logic valid;
		logic write;
		logic miss;
		logic instr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [CNT_W-1:0] parts;
		mbc_port_t port;
	} mbc_req_t;

	// Control pins toward the memory system.
	typedef struct packed {
		logic addr_latch;
		logic bus_release_strobe;
		logic read_cycle;
		logic store_cycle;
		logic burst_or_hint;
		logic fetch_info;
		logic [LOW_W-1:0] low_addr;
		logic ad_oe_n;
		logic [ADDR_W-1:0] ad_out;
	} mbc_pins_t;
endpackage

// ===== src/mbc_fill_buffer.sv
`timescale 1ns/1ps
module mbc_fill_buffer
	import mbc_pkg::*;
(
	input wire logic core_clk, // System clock.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic clear, // Start of a new transfer, read or write.
	input wire logic fill_buffer_capture, // Memory says bus data is valid.
	input wire logic [DATA_W-1:0] ad_in, // Multiplexed bus input.
	output logic [DATA_W-1:0] rd_word [BURST_WORDS], // Captured words.
	output logic [CNT_W-1:0] fill_count // Words captured so far, wrapping to zero after four.
);
	typedef struct packed {
		logic [BURST_WORDS-1:0][DATA_W-1:0] words;
		logic [CNT_W-1:0] count;
	} mbc_fb_state_t;

	mbc_fb_state_t state_reg;
	mbc_fb_state_t state_next;

	// Each capture stores the bus word at the next index.
	always_comb
	begin
		state_next = state_reg;
		if (clear)
			state_next.count = CNT_ZERO;
		else if (fill_buffer_capture)
		begin
			state_next.words[state_reg.count] = ad_in;
			state_next.count = state_reg.count + 2'h1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	// Storage is exposed as an array for the core.
	genvar gi;
	generate
		for (gi = 0; gi < BURST_WORDS; gi++)
		begin : g_out
			assign rd_word[gi] = state_reg.words[gi];
		end
	endgenerate
	assign fill_count = state_reg.count;
endmodule

// ===== src/mbc_bus_ctrl.sv
`timescale 1ns/1ps
module mbc_bus_ctrl
	import mbc_pkg::*;
(
	input wire logic core_clk, // System clock.
	input wire logic reset, // Synchronous reset, active high.
	input wire mbc_req_t req, // Core transfer request.
	input wire logic data_refill4, // Data misses refill four words.
	input wire logic ack, // Memory acknowledge, active high.
	input wire logic fill_buffer_capture, // Memory read data valid.
	input wire logic [DATA_W-1:0] ad_in, // Multiplexed bus input.
	output logic req_ready, // Request taken this cycle.
	output logic rd_done, // Read data may be used, one pulse.
	output logic wr_done, // Write finished, one pulse.
	output logic [DATA_W-1:0] rd_word [BURST_WORDS], // Read buffer.
	output mbc_pins_t pins, // Bus control pins.
	output logic bus_reference_clock // Mirror of system clock.
);
	typedef struct packed {
		mbc_state_t st;
		logic is_read;
		logic miss;
		logic instr;
		logic burst;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [CNT_W-1:0] parts;
		logic [CNT_W-1:0] part_idx;
		mbc_port_t port;
		logic [LOW_W-1:0] low;
		logic last_wr_valid;
		logic [ADDR_W-PAGE_LSB-1:0] last_page;
		logic near;
		logic rd_done;
		logic wr_done;
		mbc_pins_t pins;
	} mbc_ctl_state_t;

	mbc_ctl_state_t s_reg;
	mbc_ctl_state_t s_next;
	logic [CNT_W-1:0] fill_count;

	// Step of the low address for one datum on a given port width.
	function automatic logic [LOW_W-1:0] port_step(input mbc_port_t p);
		case (p)
			PW_32: port_step = 4'h4;
			PW_16: port_step = 4'h2;
			PW_8: port_step = 4'h1;
			default: port_step = 4'h4;
		endcase
	endfunction

	mbc_fill_buffer u_fill (
		.core_clk(core_clk),
		.reset(reset),
		.clear(req_ready),
		.fill_buffer_capture(fill_buffer_capture),
		.ad_in(ad_in),
		.rd_word(rd_word),
		.fill_count(fill_count)
	);

	assign req_ready = (s_reg.st == ST_IDLE) && req.valid;

	// Transaction sequencer and pin image.
	always_comb
	begin
		s_next = s_reg;
		s_next.rd_done = 1'b0;
		s_next.wr_done = 1'b0;
		case (s_reg.st)
			ST_IDLE:
			begin
				if (req.valid)
				begin
					s_next.st = ST_ADDR;
					s_next.is_read = ~req.write;
					s_next.miss = req.miss;
					s_next.instr = req.instr;
					// Burst only for instruction misses or opted data misses.
					s_next.burst = ~req.write & req.miss
						& (req.instr | data_refill4);
					s_next.addr = req.addr;
					s_next.wdata = req.wdata;
					s_next.parts = req.parts;
					s_next.part_idx = CNT_ZERO;
					s_next.port = req.port;
					s_next.low = req.addr[LOW_W-1:0];
					if (s_next.burst)
						s_next.low = LOW_ZERO;
					// A write directly after a write in the same page.
					s_next.near = req.write & s_reg.last_wr_valid
						& (s_reg.last_page
						== req.addr[ADDR_W-1:PAGE_LSB]);
					if (~req.write)
						s_next.last_wr_valid = 1'b0;
				end
			end
			ST_ADDR:
			begin
				// Reads turn the bus round; writes drive data at once.
				if (s_reg.is_read)
					s_next.st = ST_TURN;
				else
					s_next.st = ST_DATA;
			end
			ST_TURN:
				s_next.st = ST_DATA;
			ST_DATA:
			begin
				if (ack)
				begin
					if (s_reg.is_read)
					begin
						s_next.st = ST_IDLE;
						s_next.rd_done = 1'b1;
					end
					else if (s_reg.part_idx != s_reg.parts)
					begin
						s_next.part_idx = s_reg.part_idx + 2'h1;
						s_next.low = s_reg.low + port_step(s_reg.port);
					end
					else
					begin
						s_next.st = ST_IDLE;
						s_next.wr_done = 1'b1;
						s_next.last_wr_valid = 1'b1;
						s_next.last_page = s_reg.addr[ADDR_W-1:PAGE_LSB];
					end
				end
				// Burst counter steps after each captured word but the last.
				if (s_reg.is_read && s_reg.burst && fill_buffer_capture
					&& fill_count != CNT_LAST)
					s_next.low = s_reg.low + port_step(s_reg.port);
			end
			default:
				s_next.st = ST_IDLE;
		endcase

		// Registered pin image derived from the next state.
		s_next.pins.addr_latch = (s_next.st == ST_ADDR);
		s_next.pins.read_cycle = (s_next.st != ST_IDLE)
			& s_next.is_read;
		s_next.pins.store_cycle = (s_next.st != ST_IDLE)
			& ~s_next.is_read;
		// Release only once the device driver is already off.
		s_next.pins.bus_release_strobe = (s_next.st == ST_DATA)
			& s_next.is_read & s_reg.pins.ad_oe_n;
		s_next.pins.ad_oe_n = ~((s_next.st == ST_ADDR)
			| ((s_next.st == ST_DATA) & ~s_next.is_read));
		s_next.pins.ad_out = (s_next.st == ST_ADDR) ? s_next.addr
			: s_next.wdata;
		s_next.pins.burst_or_hint = s_next.is_read ? s_next.burst
			: s_next.near;
		// Miss flag in the address phase, fetch kind afterwards.
		if (s_next.st == ST_ADDR)
			s_next.pins.fetch_info = s_next.miss;
		else
			s_next.pins.fetch_info = s_next.instr;
		s_next.pins.low_addr = s_next.low;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			s_reg <= '0;
			s_reg.st <= ST_IDLE;
			s_reg.pins.ad_oe_n <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	// Reference clock is the system clock itself, so all state follows it.
	assign bus_reference_clock = core_clk;
	assign pins = s_reg.pins;
	assign rd_done = s_reg.rd_done;
	assign wr_done = s_reg.wr_done;
endmodule

// ===== test/mbc_chk.sv
`timescale 1ns/1ps
module mbc_chk
	import mbc_pkg::*;
(
	input wire logic core_clk, // Clock.
	input wire logic reset, // Reset.
	input wire mbc_req_t req, // Request.
	input wire logic data_refill4, // Refill option.
	input wire logic ack, // Acknowledge.
	input wire logic req_ready, // Request taken.
	input wire logic rd_done, // Read done.
	input wire logic wr_done, // Write done.
	input wire mbc_pins_t pins // Bus pins.
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Address phase of a read, then its second interval.
	chk_miss_flag: assert property
		(req_ready && !req.write |=> pins.fetch_info == $past(req.miss))
		else $error("miss flag wrong");
	chk_fetch_kind: assert property
		(req_ready && !req.write |=> ##1 pins.fetch_info == $past(req.instr, 2))
		else $error("fetch kind wrong");
	chk_latch_pulse: assert property
		(req_ready |=> pins.addr_latch && !pins.ad_oe_n
		&& pins.ad_out == $past(req.addr) ##1 !pins.addr_latch)
		else $error("address phase wrong");
	chk_release_safe: assert property
		(pins.bus_release_strobe |-> pins.ad_oe_n && $past(pins.ad_oe_n))
		else $error("bus contention");
	chk_burst_req: assert property
		(req_ready && !req.write |=> pins.burst_or_hint
		== $past(req.miss && (req.instr || data_refill4)))
		else $error("burst flag wrong");
	chk_rd_hold: assert property
		(pins.read_cycle && !ack |=> pins.read_cycle) else $error("read dropped");
	chk_wr_hold: assert property
		(pins.store_cycle && !ack |=> pins.store_cycle) else $error("write dropped");
	chk_rd_ack: assert property
		(pins.read_cycle && pins.bus_release_strobe && ack
		|=> rd_done && !pins.read_cycle) else $error("read end wrong");
	chk_wr_end: assert property
		($rose(wr_done) |-> $past(ack) && !pins.store_cycle)
		else $error("write end wrong");
	cover property (pins.burst_or_hint && pins.read_cycle);
	cover property (pins.burst_or_hint && pins.store_cycle);
	cover property (rd_done);
endmodule
bind mbc_bus_ctrl mbc_chk mbc_chk_i(.core_clk, .reset, .req, .data_refill4,
	.ack, .req_ready, .rd_done, .wr_done, .pins);

// ===== test/mbc_mem_model.sv
`timescale 1ns/1ps
module mbc_mem_model
	import mbc_pkg::*;
(
	input wire logic core_clk, // Clock.
	input wire logic reset, // Reset.
	input wire mbc_pins_t pins, // Device pins.
	input wire logic [3:0] wait_cyc, // Delay per answer, at least 1.
	output logic ack, // Acknowledge.
	output logic fill_buffer_capture, // Capture strobe.
	output logic [DATA_W-1:0] ad_in // Bus data.
);
	logic [3:0] cnt;
	logic [2:0] num;
	logic burst;
	logic active;
	// Memory answers only in the data phase.
	assign active = (pins.read_cycle && pins.bus_release_strobe)
		|| (pins.store_cycle && !pins.addr_latch);
	// Answers are spaced by wait_cyc, so a stale ack never lands twice.
	always_ff @(posedge core_clk)
	begin
		ack <= 1'b0;
		fill_buffer_capture <= 1'b0;
		ad_in <= ~ad_in; // An undriven bus keeps no stale value.
		if (pins.addr_latch)
			burst <= pins.burst_or_hint;
		if (reset || !active)
		begin
			cnt <= 4'h0;
			num <= 3'h0;
			if (reset)
				ad_in <= 32'h5A5A5A5A;
		end
		else if (cnt < wait_cyc)
			cnt <= cnt + 4'h1;
		else
		begin
			cnt <= 4'h0;
			if (pins.read_cycle && num < (burst ? 3'h4 : 3'h1))
			begin
				fill_buffer_capture <= 1'b1;
				ad_in <= {28'hBEEF123, pins.low_addr};
				num <= num + 3'h1;
			end
			else
				ack <= 1'b1;
		end
	end
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
	import mbc_pkg::*;
	logic core_clk = 1'b0, reset = 1'b1, data_refill4 = 1'b0;
	logic ack, fill_buffer_capture, req_ready, rd_done, wr_done;
	logic bus_reference_clock;
	logic [DATA_W-1:0] ad_in;
	logic [DATA_W-1:0] rd_word [BURST_WORDS];
	logic [3:0] wait_cyc = 4'h1;
	mbc_req_t req = '0;
	mbc_pins_t pins;
	int fail_count = 0, check_count = 0;
	// Free running system clock.
	always #12.5 core_clk = ~core_clk;
	mbc_bus_ctrl mbc_bus_ctrl_i(.core_clk, .reset, .req, .data_refill4, .ack,
		.fill_buffer_capture, .ad_in, .req_ready, .rd_done, .wr_done,
		.rd_word, .pins, .bus_reference_clock);
	mbc_mem_model mbc_mem_model_i(.core_clk, .reset, .pins, .wait_cyc, .ack,
		.fill_buffer_capture, .ad_in);
	task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Returns at the negedge of the first cycle after the take.
	task issue(input mbc_req_t r);
		@(negedge core_clk);
		req = r;
		#1;
		check(req_ready, 1'b1);
		@(negedge core_clk);
		req.valid = 1'b0;
	endtask
	task wait_done(input logic wr);
		for (int i = 0; i < 60; i++)
		begin
			if ((wr ? wr_done : rd_done) === 1'b1)
				return;
			@(negedge core_clk);
		end
		fail_count++;
		end_sim;
	endtask
	task t_read(input logic miss, instr, refill, burst);
		mbc_req_t r;
		r = '0;
		r.valid = 1'b1;
		r.miss = miss;
		r.instr = instr;
		r.addr = 32'h00001238;
		r.port = PW_32;
		data_refill4 = refill;
		issue(r);
		check(pins.burst_or_hint, burst);
		check(pins.fetch_info, miss);
		check(pins.read_cycle, 1'b1);
		@(negedge core_clk);
		check(pins.fetch_info, instr);
		wait_done(1'b0);
		if (burst)
			for (int i = 0; i < 4; i++)
				check(rd_word[i], {28'hBEEF123, 4'(4 * i)});
		else
			check(rd_word[0], {28'hBEEF123, 4'h8});
	endtask
	task test_reads;
		t_read(1'b1, 1'b1, 1'b0, 1'b1);
		wait_cyc = 4'h3;
		t_read(1'b1, 1'b0, 1'b0, 1'b0);
		t_read(1'b1, 1'b0, 1'b1, 1'b1);
		wait_cyc = 4'h1;
		t_read(1'b0, 1'b1, 1'b1, 1'b0);
		$display("test reads done");
	endtask
	task test_writes;
		mbc_req_t r;
		r = '0;
		r.valid = 1'b1;
		r.write = 1'b1;
		r.addr = 32'h00002010;
		r.wdata = 32'hCAFE0001;
		r.port = PW_32;
		issue(r);
		check({pins.store_cycle, pins.burst_or_hint}, 2'h2);
		@(negedge core_clk);
		check(pins.ad_out, r.wdata);
		wait_done(1'b1);
		r.addr = 32'h000020F4;
		r.port = PW_16;
		r.parts = 2'h1;
		issue(r);
		check(pins.burst_or_hint, 1'b1);
		wait_done(1'b1);
		r.addr = 32'h00002100;
		issue(r);
		check(pins.burst_or_hint, 1'b0);
		wait_done(1'b1);
		$display("test writes done");
	endtask
	task test_clock;
		@(negedge core_clk);
		check(bus_reference_clock, 1'b0);
		@(posedge core_clk);
		#1;
		check(bus_reference_clock, 1'b1);
		$display("test clock done");
	endtask
	// Reset for ten cycles, then run every scenario.
	initial
	begin
		repeat (10) @(posedge core_clk);
		@(negedge core_clk);
		reset = 1'b0;
		check({pins.ad_oe_n, pins.read_cycle, pins.store_cycle}, 3'h4);
		test_clock;
		test_reads;
		test_writes;
		end_sim;
	end
endmodule
